// File: shared/ddr2_sram_defines.svh
`ifndef DDR2_SRAM_DEFINES_SVH
`define DDR2_SRAM_DEFINES_SVH

// word width of the narrow variant
`define WORD_W 18
// external address width, bit 0 picks the burst's first word
`define ADDR_W 22
// array depth in words
`define ARRAY_DEPTH 4194304
// one write burst: address and two words
`define ENTRY_W (`ADDR_W + 2 * `WORD_W)
// entries of the write buffer toward the array
`define PAIR_DEPTH 2

`endif

// File: shared/ddr2_sram_pkg.sv
`include "ddr2_sram_defines.svh"

package ddr2_sram_pkg;

   typedef logic [`WORD_W-1:0] word_t;
   typedef logic [`ADDR_W-1:0] addr_t;

   // array-side write sequencer
   typedef enum logic [1:0] {
      ARR_IDLE,
      ARR_FIRST,
      ARR_SECOND
   } arrayPhase_t;

endpackage : ddr2_sram_pkg

// File: src/async_pair_buffer.sv
`timescale 1ns/1ps
`include "ddr2_sram_defines.svh"

module async_pair_buffer #(
   parameter int WIDTH = `ENTRY_W,
   parameter int DEPTH = `PAIR_DEPTH
) (
   input wire logic inClk,
   input wire logic outClk,
   input wire logic arst_n,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int PW = $clog2(DEPTH) + 1;

   logic [WIDTH-1:0] slot [DEPTH];
   logic [PW-1:0] wBin, wGray, rBin, rGray;
   logic [PW-1:0] rgMeta, rgSync, wgMeta, wgSync;
   logic [PW-1:0] wNext, rNext;

   function automatic logic [PW-1:0] grayToBin(input logic [PW-1:0] g);
      logic [PW-1:0] b;
      b = g;
      for (int i = PW - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction : grayToBin

   ////////////////////////////////////////////////////////////////////////
   // status from pointers, gray across domains
   assign wNext = wBin + 1'b1;
   assign rNext = rBin + 1'b1;
   assign inReady = (wBin - grayToBin(rgSync)) != PW'(DEPTH);
   assign outValid = rGray != wgSync;
   assign outData = slot[rBin[PW-2:0]];

   // filling side
   always_ff @(posedge inClk or negedge arst_n) begin
      if (!arst_n) begin
         wBin <= '0;
         wGray <= '0;
         rgMeta <= '0;
         rgSync <= '0;
      end else begin
         rgMeta <= rGray;
         rgSync <= rgMeta;
         if (inValid && inReady) begin
            wBin <= wNext;
            wGray <= wNext ^ (wNext >> 1);
         end
      end
   end

   // storage, written only on a push
   always_ff @(posedge inClk) begin
      if (inValid && inReady) begin
         slot[wBin[PW-2:0]] <= inData;
      end
   end

   // draining side
   always_ff @(posedge outClk or negedge arst_n) begin
      if (!arst_n) begin
         rBin <= '0;
         rGray <= '0;
         wgMeta <= '0;
         wgSync <= '0;
      end else begin
         wgMeta <= wGray;
         wgSync <= wgMeta;
         if (outValid && outReady) begin
            rBin <= rNext;
            rGray <= rNext ^ (rNext >> 1);
         end
      end
   end

endmodule : async_pair_buffer

// File: src/ddr2_burst2_sram_interface.sv
// Contract
// - addresses taken only on alternate input clock rising edges
// - write beats sampled on input clock and complement rising edges
// - with output clocks supplied, read beats launch on their edges
// - without output clocks, read beats launch on input clock pair
// - one-bit burst counter moves two 18-bit words per access
// - strap high gives read data 1.5 cycles after address capture
// - strap low gives read data one cycle after address capture
// - all synchronous inputs registered by input clock or complement
// - read data leaves through output registers on the launch clocks
// - two echo strobes aligned with read data
// - shared data pins, read and write beats never overlap
// - array writes self-timed internally, no pulse from controller
// - array holds 4M words of 18 bits
`timescale 1ns/1ps
`include "ddr2_sram_defines.svh"

module ddr2_burst2_sram_interface (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic kClk,
   input wire logic kClkN,
   input wire logic cClk,
   input wire logic cClkN,
   input wire logic outClkSupplied,
   input wire logic latency_strap,
   input wire logic loadN,
   input wire logic readNotWrite,
   input wire ddr2_sram_pkg::addr_t address,
   input wire ddr2_sram_pkg::word_t dqIn,
   output ddr2_sram_pkg::word_t dqOut,
   output logic dqOe,
   output logic echo_strobe,
   output logic echo_strobeN,
   output logic writeStall
);
   import ddr2_sram_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // state of the link side, clocked by the input clock
   typedef struct packed {
      // strap synchronisers
      logic strapMeta;
      logic strapSync;
      logic cselMeta;
      logic cselSync;

      // command spacing
      logic cmdSkip;

      // read pipeline, two stages
      logic rdValid;
      word_t rdA;
      word_t rdB;
      logic stValid;
      word_t stA;
      word_t stB;

      // write beats being gathered
      logic wrStage;
      logic wrCollect;
      addr_t wrAddr;
      word_t wrBeat0;

      // burst waiting for the buffer
      logic pushValid;
      addr_t pushAddr;
      word_t pushW0;
      word_t pushW1;

      // back-pressure to the controller
      logic stall;
   } linkState_t;

   // state of the array side, clocked by clk
   typedef struct packed {
      // write sequencer step
      arrayPhase_t phase;
      // burst being written
      addr_t addr;
      word_t w0;
      word_t w1;
   } arrayState_t;

   linkState_t link, next_link;
   arrayState_t arr, next_arr;

   // the array itself
   word_t mem [`ARRAY_DEPTH];

   // second write beat, caught on the complement rise
   word_t fallBeat;

   // launch registers, one set per launch edge
   word_t riseData;
   word_t fallData;
   logic riseOe;
   logic fallOe;
   logic riseEcho;
   logic fallEcho;

   // launch clocks after the supply choice
   logic riseLaunch;
   logic fallLaunch;

   // command decode
   addr_t partner;
   logic takeCmd;

   // handshake with the crossing buffer
   logic bufReady;
   logic bufValid;
   logic bufPop;
   logic [`ENTRY_W-1:0] bufIn;
   logic [`ENTRY_W-1:0] bufOut;

   // array write port
   logic memWe;
   addr_t memAddr;
   word_t memData;

   ////////////////////////////////////////////////////////////////////////
   // launch clock choice: output pair when supplied, else input pair
   assign riseLaunch = link.cselSync ? cClk : kClk;
   assign fallLaunch = link.cselSync ? cClkN : kClkN;

   // burst partner address: lsb flipped
   assign partner = {address[`ADDR_W-1:1], ~address[0]};

   // command accepted only when the previous edge took none
   assign takeCmd = !loadN && !link.cmdSkip;

   // write burst handed to the array side
   assign bufIn = {link.pushAddr, link.pushW0, link.pushW1};

   ////////////////////////////////////////////////////////////////////////
   // link side next state
   always_comb begin
      next_link = link;
      // straps pass two flops before use
      next_link.strapMeta = latency_strap;
      next_link.strapSync = link.strapMeta;
      next_link.cselMeta = outClkSupplied;
      next_link.cselSync = link.cselMeta;

      // one-shot read and write markers
      next_link.rdValid = 1'b0;
      next_link.wrStage = 1'b0;
      next_link.wrCollect = 1'b0;
      next_link.cmdSkip = 1'b0;

      // read burst moves to the second stage one cycle on
      next_link.stValid = link.rdValid;
      next_link.stA = link.rdA;
      next_link.stB = link.rdB;

      // a new command, unless the last edge took one
      if (takeCmd) begin
         next_link.cmdSkip = 1'b1;
         if (readNotWrite) begin
            // both words fetched, given address first
            next_link.rdValid = 1'b1;
            next_link.rdA = mem[address];
            next_link.rdB = mem[partner];
         end else begin
            next_link.wrStage = 1'b1;
            next_link.wrAddr = address;
         end
      end

      // first write beat on the next input clock rise
      if (link.wrStage) begin
         next_link.wrBeat0 = dqIn;
         next_link.wrCollect = 1'b1;
      end

      // drain a pending burst into the buffer
      if (link.pushValid && bufReady) begin
         next_link.pushValid = 1'b0;
      end

      // second beat came on the complement edge; burst complete
      if (link.wrCollect) begin
         next_link.pushValid = 1'b1;
         next_link.pushAddr = link.wrAddr;
         next_link.pushW0 = link.wrBeat0;
         next_link.pushW1 = fallBeat;
      end

      // back-pressure seen by the controller
      next_link.stall = next_link.pushValid && !bufReady;
   end

   // link side registers
   always_ff @(posedge kClk or negedge arst_n) begin
      if (!arst_n) begin
         link <= '0;
      end else begin
         link <= next_link;
      end
   end

   // second write beat on the complement clock rise
   always_ff @(posedge kClkN or negedge arst_n) begin
      if (!arst_n) begin
         fallBeat <= '0;
      end else begin
         fallBeat <= dqIn;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // output registers on the rising launch edge
   always_ff @(posedge riseLaunch or negedge arst_n) begin
      if (!arst_n) begin
         riseData <= '0;
         riseOe <= 1'b0;
         riseEcho <= 1'b0;
      end else begin
         riseEcho <= ~fallEcho;
         if (link.strapSync) begin
            // second word two cycles after capture
            riseData <= link.stB;
            riseOe <= link.stValid && !link.wrStage;
         end else begin
            // first word one cycle after capture
            riseData <= link.rdA;
            riseOe <= link.rdValid && !link.wrStage;
         end
      end
   end

   // output registers on the complement launch edge
   always_ff @(posedge fallLaunch or negedge arst_n) begin
      if (!arst_n) begin
         fallData <= '0;
         fallOe <= 1'b0;
         fallEcho <= 1'b0;
      end else begin
         fallEcho <= riseEcho;
         if (link.strapSync) begin
            // first word 1.5 cycles after capture
            fallData <= link.stA;
         end else begin
            // second word 1.5 cycles after capture
            fallData <= link.stB;
         end
         fallOe <= link.stValid && !link.wrCollect;
      end
   end

   // pins follow whichever launch register fired last
   always_comb begin
      if (riseLaunch) begin
         // rising launch edge owns the high half
         dqOut = riseData;
         dqOe = riseOe;
      end else begin
         // complement edge owns the low half
         dqOut = fallData;
         dqOe = fallOe;
      end
   end

   // echo pair follows the launch flops
   assign echo_strobe = riseEcho ^ fallEcho;
   assign echo_strobeN = ~(riseEcho ^ fallEcho);

   // stall straight from the link register
   assign writeStall = link.stall;

   ////////////////////////////////////////////////////////////////////////
   // write bursts cross to the array clock
   async_pair_buffer #(
      .WIDTH(`ENTRY_W),
      .DEPTH(`PAIR_DEPTH)
   ) writeBuffer (
      .inClk(kClk),
      .outClk(clk),
      .arst_n(arst_n),
      .inValid(link.pushValid),
      .inReady(bufReady),
      .inData(bufIn),
      .outValid(bufValid),
      .outReady(bufPop),
      .outData(bufOut)
   );

   ////////////////////////////////////////////////////////////////////////
   // array side: self-timed two-word write sequence
   assign bufPop = arr.phase == ARR_IDLE;

   always_comb begin
      next_arr = arr;
      // defaults: no write, first word at the given address
      memWe = 1'b0;
      memAddr = arr.addr;
      memData = arr.w0;
      case (arr.phase)
         ARR_IDLE: begin
            if (bufValid) begin
               next_arr.addr = bufOut[`ENTRY_W-1 -: `ADDR_W];
               next_arr.w0 = bufOut[2*`WORD_W-1 -: `WORD_W];
               next_arr.w1 = bufOut[`WORD_W-1:0];
               next_arr.phase = ARR_FIRST;
            end
         end

         ARR_FIRST: begin
            // given address bit first
            memWe = 1'b1;
            next_arr.phase = ARR_SECOND;
         end

         ARR_SECOND: begin
            // complemented address bit second
            memWe = 1'b1;
            memAddr = {arr.addr[`ADDR_W-1:1], ~arr.addr[0]};
            memData = arr.w1;
            next_arr.phase = ARR_IDLE;
         end

         default: begin
            // unused encoding returns to idle
            next_arr.phase = ARR_IDLE;
         end
      endcase
   end

   // array side registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         arr <= '{phase: ARR_IDLE, default: '0};
      end else begin
         arr <= next_arr;
      end
   end

   // array write port
   always_ff @(posedge clk) begin
      if (memWe) begin
         mem[memAddr] <= memData;
      end
   end

endmodule : ddr2_burst2_sram_interface

// File: testbench/ddr2_sram_monitor.sv
`timescale 1ns/1ps
module ddr2_sram_monitor (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic kClk,
   input wire logic latency_strap,
   input wire logic loadN,
   input wire logic readNotWrite,
   input wire ddr2_sram_pkg::word_t dqOut,
   input wire logic dqOe,
   input wire logic echo_strobe,
   input wire logic echo_strobeN,
   input wire logic writeStall
);
   import ddr2_sram_pkg::*;
   logic takenPrev, rdTaken, wrTaken;
   logic [3:0] sinceRead;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // commands accepted on alternate input clock rises
   always_ff @(posedge kClk or negedge arst_n) begin
      if (!arst_n) begin
         takenPrev <= 1'b0;
         rdTaken <= 1'b0;
         wrTaken <= 1'b0;
      end else begin
         takenPrev <= !loadN && !takenPrev;
         rdTaken <= !loadN && !takenPrev && readNotWrite;
         wrTaken <= !loadN && !takenPrev && !readNotWrite;
      end
   end
   // array clock cycles since the last accepted read
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         sinceRead <= 4'hF;
      else if ($rose(rdTaken))
         sinceRead <= 4'h1;
      else if (sinceRead != 4'hF)
         sinceRead <= sinceRead + 4'h1;
   end
   a_low_latency: assert property (
      $rose(rdTaken) && !latency_strap |->
      !dqOe[*4] ##1 dqOe[*4] ##1 !dqOe) else $error("late low read");
   a_high_latency: assert property (
      $rose(rdTaken) && latency_strap |->
      ##2 !dqOe[*4] ##1 dqOe[*4] ##1 !dqOe) else $error("bad high read");
   a_write_no_drive: assert property (
      $rose(wrTaken) |-> ##2 !dqOe[*7]) else $error("drive in write");
   a_drive_after_read: assert property (
      dqOe |-> sinceRead inside {4'h1, [4'h4:4'h9]})
      else $error("drive without read");
   a_bus_turnaround: assert property (
      $fell(dqOe) |-> !dqOe[*4]) else $error("no turnaround");
   a_beat_stable: assert property (
      $rose(dqOe) |=> $stable(dqOut) ##2 $stable(dqOut))
      else $error("beat not held");
   a_echo_pair: assert property (
      echo_strobe != echo_strobeN) else $error("echo pair equal");
   a_stall_bounded: assert property (
      writeStall |-> ##[1:40] !writeStall) else $error("stall stuck");
endmodule : ddr2_sram_monitor

bind ddr2_burst2_sram_interface ddr2_sram_monitor mon (.clk(clk),
   .arst_n(arst_n), .kClk(kClk), .latency_strap(latency_strap),
   .loadN(loadN), .readNotWrite(readNotWrite), .dqOut(dqOut),
   .dqOe(dqOe), .echo_strobe(echo_strobe),
   .echo_strobeN(echo_strobeN), .writeStall(writeStall));

// File: testbench/sram_ctrl_model.sv
`timescale 1ns/1ps
module sram_ctrl_model (
   output logic kClk,
   output logic kClkN,
   output logic cClk,
   output logic cClkN,
   input wire logic runOutClk,
   output logic loadN,
   output logic readNotWrite,
   output ddr2_sram_pkg::addr_t address,
   output ddr2_sram_pkg::word_t dqIn,
   input wire ddr2_sram_pkg::word_t dqOut,
   input wire logic dqOe,
   input wire logic writeStall
);
   import ddr2_sram_pkg::*;
   // free-running input pair, phase offset from the array clock
   initial begin
      kClk = 1'b0;
      #7;
      forever #40 kClk = ~kClk;
   end
   assign kClkN = ~kClk;
   // output pair stands still when not supplied
   assign cClk = runOutClk & kClk;
   assign cClkN = runOutClk & kClkN;
   initial begin
      loadN = 1'b1;
      readNotWrite = 1'b1;
      address = '0;
      dqIn = '0;
   end
   // one command for one rise, or held over a second rise
   task automatic command(input logic rnw, input addr_t a, input logic hold);
      @(posedge kClk);
      #1;
      loadN = 1'b0;
      readNotWrite = rnw;
      address = a;
      @(posedge kClk);
      if (hold)
         @(posedge kClk);
      #1;
      loadN = 1'b1;
      address = ~a;
   endtask : command
   task automatic write_burst(input addr_t a, input word_t w0,
         input word_t w1);
      for (int i = 0; i < 50 && writeStall; i++)
         @(posedge kClk);
      command(1'b0, a, 1'b0);
      dqIn = w0;
      @(posedge kClk);
      #1;
      dqIn = w1;
      @(posedge kClkN);
      #1;
      dqIn = ~w1; // no stale value after the beat
   endtask : write_burst
   // samples each beat in its middle
   task automatic read_burst(input addr_t a, input logic hold,
         input logic late, output word_t b0, output word_t b1,
         output logic oe0, output logic oeEnd);
      command(1'b1, a, hold);
      #(98 + (late ? 40 : 0) - (hold ? 80 : 0));
      b0 = dqOut;
      oe0 = dqOe;
      #40;
      b1 = dqOut;
      #40;
      oeEnd = dqOe;
   endtask : read_burst
endmodule : sram_ctrl_model

// File: testbench/tb.sv
`timescale 1ns/1ps
module tb;
   import ddr2_sram_pkg::*;
   logic clk, arst_n, latencyStrap, outSupplied, kClk, kClkN, cClk;
   logic cClkN, loadN, readNotWrite, dqOe, echoStrobe, echoStrobeN;
   logic writeStall;
   addr_t address;
   word_t dqIn, dqOut;
   int miscompares = 0;
   int checks = 0;
   sram_ctrl_model ctrl (.kClk(kClk), .kClkN(kClkN), .cClk(cClk),
      .cClkN(cClkN), .runOutClk(outSupplied), .loadN(loadN),
      .readNotWrite(readNotWrite), .address(address), .dqIn(dqIn),
      .dqOut(dqOut), .dqOe(dqOe), .writeStall(writeStall));
   ddr2_burst2_sram_interface uut (.clk(clk), .arst_n(arst_n),
      .kClk(kClk), .kClkN(kClkN), .cClk(cClk), .cClkN(cClkN),
      .outClkSupplied(outSupplied), .latency_strap(latencyStrap),
      .loadN(loadN), .readNotWrite(readNotWrite), .address(address),
      .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .echo_strobe(echoStrobe),
      .echo_strobeN(echoStrobeN), .writeStall(writeStall));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic check(input word_t seen, input word_t want);
      checks++;
      if (seen !== want) begin
         miscompares++;
         $display("CHECK FAILED %0t got %h want %h", $time, seen, want);
      end
   endtask : check
   task automatic report_and_stop;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop
   task automatic set_mode(input logic late, input logic outs);
      @(posedge clk);
      #1;
      latencyStrap = late;
      outSupplied = outs;
      repeat (4) @(posedge kClk);
   endtask : set_mode
   task automatic read_expect(input addr_t a, input logic hold,
         input word_t e0, input word_t e1);
      word_t b0, b1;
      logic oe0, oeEnd;
      ctrl.read_burst(a, hold, latencyStrap, b0, b1, oe0, oeEnd);
      check(b0, e0);
      check(b1, e1);
      check(word_t'(oe0), 18'h00001);
      check(word_t'(oeEnd), 18'h00000);
   endtask : read_expect
   task automatic t_write_read;
      ctrl.write_burst(22'h001234, 18'h2A5A5, 18'h15A5A);
      repeat (20) @(posedge clk);
      read_expect(22'h001234, 1'b0, 18'h2A5A5, 18'h15A5A);
      read_expect(22'h001235, 1'b0, 18'h15A5A, 18'h2A5A5);
   endtask : t_write_read
   task automatic t_modes;
      set_mode(1'b1, 1'b1);
      read_expect(22'h001234, 1'b0, 18'h2A5A5, 18'h15A5A);
      set_mode(1'b0, 1'b0);
      read_expect(22'h001235, 1'b0, 18'h15A5A, 18'h2A5A5);
      set_mode(1'b0, 1'b1);
      read_expect(22'h001234, 1'b1, 18'h2A5A5, 18'h15A5A);
   endtask : t_modes
   task automatic t_stream;
      addr_t adr [4] = '{22'h3FFFFE, 22'h000003, 22'h155554, 22'h2AAAA9};
      for (int i = 0; i < 4; i++)
         ctrl.write_burst(adr[i], word_t'(18'h12340 + i),
            word_t'(18'h2DCB0 - i));
      repeat (30) @(posedge clk);
      check(word_t'(writeStall), 18'h00000);
      for (int i = 0; i < 4; i++)
         read_expect(adr[i], 1'b0, word_t'(18'h12340 + i),
            word_t'(18'h2DCB0 - i));
   endtask : t_stream
   task automatic t_echo;
      @(posedge kClk);
      #10;
      check(word_t'(echoStrobe), 18'h00001);
      check(word_t'(echoStrobeN), 18'h00000);
      @(posedge kClkN);
      #10;
      check(word_t'(echoStrobe), 18'h00000);
      check(word_t'(echoStrobeN), 18'h00001);
   endtask : t_echo
   initial begin
      arst_n = 1'b0;
      latencyStrap = 1'b0;
      outSupplied = 1'b1;
      repeat (2) @(posedge kClk);
      @(posedge clk);
      #1;
      arst_n = 1'b1;
      repeat (3) @(posedge kClk);
      t_write_read();
      t_modes();
      t_stream();
      t_echo();
      report_and_stop();
   end
   // cut a hang short
   initial begin
      #300000;
      miscompares++;
      report_and_stop();
   end
endmodule : tb
